// ==== rtl/channel_coupler.sv ====
/*
  Dual-access channel coupler: connect arbitration, function checking,
  autoload sequencing, data/status path selection and A/D control.
  Assumes all channel inputs are asynchronous pulses or levels and that
  the subsystem processor strobes are on ref_clk.
*/
`timescale 1ns/1ps
module channel_coupler #(
  parameter int unsigned DEADMAN_CYCLES = coupler_pkg::DEADMAN_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Peripheral processor channels A and B
  input coupler_pkg::chan_in_s chan_a,
  input coupler_pkg::chan_in_s chan_b,
  input wire logic [11:0] chan_a_data,
  input wire logic [11:0] chan_b_data,
  output logic chan_a_inactive,
  output logic chan_b_inactive,
  output logic chan_a_empty,
  output logic chan_b_empty,
  output logic chan_a_full,
  output logic chan_b_full,
  output logic [11:0] chan_out_data,
  // Build option
  input wire logic dual_access,
  // Subsystem processor controls
  input wire logic [3:0] format,
  input wire logic [1:0] data_path,
  input wire logic [3:0] status_select_lines,
  input wire logic [15:0] status_sources,
  input wire logic proc_inactive,
  input wire logic processor_clear_echo,
  input wire logic input_request,
  input wire logic parity_check,
  output logic [1:0] status_code,
  output logic [15:0] status_input_lines,
  output logic [15:0] coupler_input_word_lines,
  output logic coupler_reply,
  output logic coupler_ready,
  output logic coupler_terminate,
  output logic cycle_stop,
  output logic proc_master_clear,
  output logic force_function,
  output logic go,
  // Observed state
  output logic connect_a,
  output logic connect_b,
  output logic reserved,
  output logic [3:0] frame_count,
  output logic [3:0] write_decode,
  output logic [3:0] read_decode,
  output logic [1:0] reg_load
);
  // ============================================================
  // Synchronisers and edge detectors
  // ============================================================
  logic [7:0] sync1;
  logic [7:0] sync2;
  logic [7:0] sync3;
  logic [7:0] rise;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
      sync3 <= 8'h00;
    end else begin
      sync1 <= {chan_b, chan_a};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  assign rise = sync2 & ~sync3;
  // Bit layout per access: [3]=function [2]=active [1]=inactive [0]=full.
  logic [1:0] fn_p, act_p, inact_p, full_p;
  assign fn_p = {rise[7], rise[3]};
  assign act_p = {rise[6], rise[2]};
  assign inact_p = {rise[5], rise[1]};
  assign full_p = {rise[4], rise[0]};

  // ============================================================
  // Scan divider and deadman
  // ============================================================
  logic [1:0] scan_cnt, next_scan_cnt;
  logic scan_a, next_scan_a;
  logic [31:0] dead_cnt, next_dead_cnt;
  logic dead_exp;
  logic autoload_pulse, ad_clear;
  logic [3:0] al_state, next_al_state;
  always_comb begin
    next_scan_cnt = scan_cnt + 2'd1;
    next_scan_a = scan_a;
    if (scan_cnt == 2'(coupler_pkg::SCAN_HALF_CYC - 1)) begin
      next_scan_cnt = 2'd0;
      next_scan_a = ~scan_a;
    end
    next_dead_cnt = dead_cnt;
    if (!reserved || parity_check || autoload_pulse) begin
      next_dead_cnt = 32'd0;
    end else if (!dead_exp) begin
      next_dead_cnt = dead_cnt + 32'd1;
    end
  end
  assign dead_exp = (dead_cnt >= DEADMAN_CYCLES);
  // Scan B is the complement of scan A, so their falling edges never coincide.
  logic [1:0] scan_fall, scan_rise;
  assign scan_fall = {next_scan_a != scan_a && scan_a == 1'b0,
                      next_scan_a != scan_a && scan_a == 1'b1};
  assign scan_rise = {scan_fall[0], scan_fall[1]};

  // ============================================================
  // Connect logic per access
  // ============================================================
  logic [1:0] fn_hold, next_fn_hold, fn_latch, next_fn_latch, conn, next_conn;
  logic [1:0] drop_req, next_drop_req, stat_seq, next_stat_seq;
  logic [1:0] os_cnt [2];
  logic [1:0] next_os_cnt [2];
  logic [11:0] fn_code [2];
  logic [11:0] next_fn_code [2];
  logic [1:0] merged_fn;
  logic eq_nonzero;
  always_comb begin
    next_fn_hold = fn_hold;
    next_fn_latch = fn_latch;
    next_conn = conn;
    next_drop_req = drop_req;
    next_stat_seq = stat_seq;
    next_os_cnt = os_cnt;
    next_fn_code = fn_code;
    for (int i = 0; i < 2; i++) begin
      if (fn_p[i]) begin
        next_fn_hold[i] = 1'b1;
        next_fn_code[i] = (i == 0) ? chan_a_data : chan_b_data;
        next_os_cnt[i] = 2'(coupler_pkg::ONESHOT_CYC);
      end
      if (os_cnt[i] != 2'd0) begin
        next_os_cnt[i] = os_cnt[i] - 2'd1;
        if (os_cnt[i] == 2'd1) next_fn_latch[i] = 1'b1;
      end
      if (inact_p[i]) begin
        next_fn_hold[i] = 1'b0;
        next_fn_latch[i] = 1'b0;
      end
      if (fn_latch[i] && !conn[1-i] && !dead_exp && scan_fall[i]) begin
        next_conn[i] = 1'b1;
        next_fn_latch[i] = 1'b0;
      end
      if (fn_latch[i] && conn[1-i] && fn_code[i] == coupler_pkg::STATUS_CODE
          && scan_fall[i]) begin
        next_stat_seq[i] = 1'b1;
        next_fn_latch[i] = 1'b0;
      end
      if (stat_seq[i] && (full_p[i] || !conn[1-i])) next_stat_seq[i] = 1'b0;
      if (conn[i] && ((merged_fn[i] && eq_nonzero) || proc_inactive || ad_clear
          || dead_exp)) begin
        next_drop_req[i] = 1'b1;
      end
      if (drop_req[i] && scan_rise[i]) begin
        next_conn[i] = 1'b0;
        next_drop_req[i] = 1'b0;
        next_fn_hold[i] = 1'b0;
      end
      if (!dual_access) next_conn[i] = 1'b0;
    end
  end
  // Single-access builds pass access A's function straight through.
  assign merged_fn = dual_access ? (conn & fn_hold) : {1'b0, fn_hold[0]};
  logic [11:0] chk_code;
  assign chk_code = merged_fn[1] ? fn_code[1] : fn_code[0];
  assign eq_nonzero = chk_code[11:9] != coupler_pkg::EQUIP_ZERO;

  // ============================================================
  // Function checking, autoload sequence and data transfer
  // ============================================================
  logic in_process, next_in_process, autoload, next_autoload;
  logic next_reserved, data_mode, next_data_mode;
  logic [11:0] upper, next_upper, lower, next_lower;
  logic [1:0] held, next_held;
  logic [3:0] next_frame_count;
  logic [1:0] next_empty, next_inactive, next_full_o;
  logic next_reply, next_term, last_seen, next_last_seen;
  logic [3:0] fmt_eff;
  logic [1:0] path_eff;
  logic [1:0] cur;
  coupler_pkg::ad_ctrl_s ad;
  assign fmt_eff = processor_clear_echo ? coupler_pkg::FORMAT_AUTOLOAD : format;
  assign path_eff = processor_clear_echo ? coupler_pkg::PATH_PROC_PERIPH : data_path;
  // Access A is the default path; B is chosen only while B is connected.
  assign cur = conn[1] ? 2'b10 : 2'b01;
  assign autoload_pulse = (|merged_fn) && !in_process && !eq_nonzero
                          && chk_code == coupler_pkg::AUTOLOAD_CODE;
  assign ad_clear = autoload_pulse;

  always_comb begin
    next_in_process = in_process;
    next_autoload = autoload;
    next_reserved = reserved;
    next_data_mode = data_mode;
    next_upper = upper;
    next_lower = lower;
    next_held = held;
    next_frame_count = frame_count;
    next_empty = 2'b00;
    next_inactive = 2'b00;
    next_full_o = {stat_seq[1] & act_p[1], stat_seq[0] & act_p[0]};
    next_reply = 1'b0;
    next_term = 1'b0;
    next_last_seen = last_seen;
    next_al_state = al_state;
    if (|merged_fn && !in_process) begin
      next_autoload = 1'b0;
      next_in_process = !eq_nonzero;
      if (!eq_nonzero) next_reserved = 1'b1;
    end
    if (autoload_pulse) begin
      next_autoload = 1'b1;
      next_reserved = 1'b1;
      next_inactive = cur;
      next_held = 2'b00;
      next_al_state = coupler_pkg::AL_FILL;
    end
    next_inactive = next_inactive | {stat_seq[1] & ~stat_seq[1], 1'b0}
                    | {(next_stat_seq[1] & ~stat_seq[1]), (next_stat_seq[0] & ~stat_seq[0])};
    if (|(act_p & cur) && reserved) begin
      next_data_mode = 1'b1;
      next_frame_count = ad.max_count;
    end
    unique case (al_state)
      coupler_pkg::AL_IDLE: ;
      coupler_pkg::AL_FILL: begin
        if (data_mode && |(full_p & cur)) begin
          if (!held[0]) begin
            next_upper = conn[1] ? chan_b_data : chan_a_data;
            next_held = 2'b01;
            next_empty = cur;
          end else begin
            next_lower = conn[1] ? chan_b_data : chan_a_data;
            next_held = 2'b11;
            next_empty = cur;
            next_al_state = coupler_pkg::AL_OFFER;
          end
        end
        if (data_mode && |(inact_p & cur)) begin
          next_last_seen = 1'b1;
          if (held[0]) next_al_state = coupler_pkg::AL_OFFER;
          else next_al_state = coupler_pkg::AL_DONE;
        end
      end
      coupler_pkg::AL_OFFER: begin
        if (data_mode && |(inact_p & cur)) next_last_seen = 1'b1;
        if (input_request && !coupler_reply) begin
          next_reply = 1'b1;
          next_term = last_seen || |(inact_p & cur);
        end
        if (parity_check) begin
          next_held = 2'b00;
          next_frame_count = (frame_count <= 4'd1) ? ad.max_count
                             : frame_count - 4'd1;
          next_al_state = (next_last_seen) ? coupler_pkg::AL_DONE
                                            : coupler_pkg::AL_FILL;
        end
      end
      coupler_pkg::AL_DONE: begin
        next_autoload = 1'b0;
        next_reserved = 1'b0;
        next_data_mode = 1'b0;
        next_in_process = 1'b0;
        next_last_seen = 1'b0;
        next_al_state = coupler_pkg::AL_IDLE;
      end
      default: next_al_state = coupler_pkg::AL_IDLE;
    endcase
    if (dead_exp || (|(inact_p & cur)) || proc_inactive) begin
      next_reserved = 1'b0;
      next_in_process = 1'b0;
      next_data_mode = 1'b0;
      if (!autoload_pulse) next_autoload = 1'b0;
    end
  end

  ad_control u_ad (
    .format(fmt_eff),
    .frame_count(frame_count),
    .ctrl(ad)
  );

  // ============================================================
  // Registers
  // ============================================================
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      scan_cnt <= 2'd0;
      scan_a <= 1'b0;
      dead_cnt <= 32'd0;
      fn_hold <= 2'b00;
      fn_latch <= 2'b00;
      conn <= 2'b00;
      drop_req <= 2'b00;
      stat_seq <= 2'b00;
      os_cnt <= '{2'd0, 2'd0};
      fn_code <= '{12'h000, 12'h000};
      in_process <= 1'b0;
      autoload <= 1'b0;
      reserved <= 1'b0;
      data_mode <= 1'b0;
      upper <= 12'h000;
      lower <= 12'h000;
      held <= 2'b00;
      frame_count <= coupler_pkg::FRAME_RESET;
      al_state <= coupler_pkg::AL_IDLE;
      last_seen <= 1'b0;
      {chan_b_empty, chan_a_empty} <= 2'b00;
      {chan_b_inactive, chan_a_inactive} <= 2'b00;
      {chan_b_full, chan_a_full} <= 2'b00;
      coupler_reply <= 1'b0;
      coupler_terminate <= 1'b0;
    end else begin
      scan_cnt <= next_scan_cnt;
      scan_a <= next_scan_a;
      dead_cnt <= next_dead_cnt;
      fn_hold <= next_fn_hold;
      fn_latch <= next_fn_latch;
      conn <= next_conn;
      drop_req <= next_drop_req;
      stat_seq <= next_stat_seq;
      os_cnt <= next_os_cnt;
      fn_code <= next_fn_code;
      in_process <= next_in_process;
      autoload <= next_autoload;
      reserved <= next_reserved;
      data_mode <= next_data_mode;
      upper <= next_upper;
      lower <= next_lower;
      held <= next_held;
      frame_count <= next_frame_count;
      al_state <= next_al_state;
      last_seen <= next_last_seen;
      {chan_b_empty, chan_a_empty} <= next_empty;
      {chan_b_inactive, chan_a_inactive} <= next_inactive;
      {chan_b_full, chan_a_full} <= next_full_o;
      coupler_reply <= next_reply;
      coupler_terminate <= next_term;
    end
  end

  // ============================================================
  // Output registers: paths, status, initiation and observation
  // ============================================================
  logic [1:0] sel_enc;
  logic [3:0] init_seq;
  always_comb begin
    sel_enc = 2'd0;
    for (int k = 3; k >= 0; k--) begin
      if (status_select_lines[k]) sel_enc = 2'(k);
    end
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_code <= 2'd0;
      status_input_lines <= 16'h0000;
      coupler_input_word_lines <= 16'h0000;
      chan_out_data <= 12'h000;
      init_seq <= 4'h0;
      {cycle_stop, proc_master_clear, force_function, go} <= 4'h0;
      coupler_ready <= 1'b0;
      connect_a <= 1'b0;
      connect_b <= 1'b0;
      write_decode <= 4'h0;
      read_decode <= 4'h0;
      reg_load <= 2'd0;
    end else begin
      status_code <= sel_enc;
      status_input_lines <= status_sources >> {sel_enc, 2'b00};
      coupler_input_word_lines <= (path_eff == coupler_pkg::PATH_PROC_PERIPH)
                                  ? {upper[7:0], lower[7:0]} : 16'h0000;
      chan_out_data <= 12'((stat_seq != 2'b00) << coupler_pkg::RESERVED_BIT);
      init_seq <= autoload_pulse ? 4'b0001 : {init_seq[2:0], 1'b0};
      {cycle_stop, proc_master_clear, force_function, go} <=
        {init_seq[0], init_seq[1], init_seq[2], init_seq[3]};
      coupler_ready <= next_autoload;
      connect_a <= next_conn[0];
      connect_b <= next_conn[1];
      write_decode <= fmt_eff[0] ? 4'h0 : ad.write_decode;
      read_decode <= fmt_eff[0] ? ad.read_decode : 4'h0;
      reg_load <= ad.load;
    end
  end

  // ============================================================
  // Assertions and cover points
  // ============================================================
  property p_scan_apart;
    @(posedge ref_clk) disable iff (!arst_n) !(scan_fall[0] && scan_fall[1]);
  endproperty
  a_scan_apart: assert property (p_scan_apart) else $error("scan edges coincide");
  property p_conn_excl;
    @(posedge ref_clk) disable iff (!arst_n) !(conn[0] && conn[1]);
  endproperty
  a_conn_excl: assert property (p_conn_excl) else $error("both accesses connected");
  property p_single;
    @(posedge ref_clk) disable iff (!arst_n) !dual_access |=> conn == 2'b00;
  endproperty
  a_single: assert property (p_single) else $error("connect in single build");
  property p_init_order;
    @(posedge ref_clk) disable iff (!arst_n)
      autoload_pulse |-> ##2 cycle_stop ##1 proc_master_clear ##1 force_function ##1 go;
  endproperty
  a_init_order: assert property (p_init_order) else $error("initiation order wrong");
  property p_al_reply;
    @(posedge ref_clk) disable iff (!arst_n)
      autoload_pulse |=> (chan_a_inactive || chan_b_inactive);
  endproperty
  a_al_reply: assert property (p_al_reply) else $error("no inactive reply");
  property p_term_reply;
    @(posedge ref_clk) disable iff (!arst_n) coupler_terminate |-> coupler_reply;
  endproperty
  a_term_reply: assert property (p_term_reply) else $error("terminate without word");
  property p_dead_clear;
    @(posedge ref_clk) disable iff (!arst_n) dead_exp |=> !reserved;
  endproperty
  a_dead_clear: assert property (p_dead_clear) else $error("reserve kept on expiry");
  c_autoload: cover property (@(posedge ref_clk) disable iff (!arst_n) autoload_pulse);
  c_terminate: cover property (@(posedge ref_clk) disable iff (!arst_n) coupler_terminate);
  c_status_reply: cover property (@(posedge ref_clk) disable iff (!arst_n) stat_seq != 2'b00);
endmodule : channel_coupler

// ==== shared/coupler_pkg.sv ====
/*
  Constants, enumerations and carrier structs for the channel coupler
  connect, assembly/disassembly control and autoload logic.
  Assumes a 10 MHz coupler clock.
*/
package coupler_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned ONESHOT_NS = 60;
  localparam int unsigned ONESHOT_CYC =
    ((ONESHOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
    (ONESHOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEADMAN_S = 4;
  localparam int unsigned DEADMAN_CYC = DEADMAN_S * (1000000000 / CLK_PERIOD_NS);
  localparam int unsigned SCAN_HALF_CYC = 2;
  localparam logic [11:0] AUTOLOAD_CODE = 12'h10C;
  localparam logic [11:0] STATUS_CODE = 12'h00A;
  localparam logic [2:0] EQUIP_ZERO = 3'h0;
  localparam logic [3:0] FORMAT_AUTOLOAD = 4'h0;
  localparam logic [1:0] PATH_PROC_PERIPH = 2'h0;
  localparam logic [3:0] FRAME_RESET = 4'h1;
  localparam int unsigned RESERVED_BIT = 10;

  typedef enum logic [1:0] {
    REG_NONE = 2'h0,
    REG_UPPER = 2'h1,
    REG_LOWER = 2'h2,
    REG_BOTH = 2'h3
  } reg_load_e;

  typedef enum logic [3:0] {
    AL_IDLE = 4'b0001,
    AL_FILL = 4'b0010,
    AL_OFFER = 4'b0100,
    AL_DONE = 4'b1000
  } al_state_e;

  typedef struct packed {
    reg_load_e load;
    logic [3:0] write_decode;
    logic [3:0] read_decode;
    logic [3:0] max_count;
  } ad_ctrl_s;

  typedef struct packed {
    logic function_pulse;
    logic active;
    logic inactive;
    logic full;
  } chan_in_s;
endpackage : coupler_pkg

// ==== rtl/ad_control.sv ====
/*
  Assembly/disassembly control lookup: format and frame count to data
  register clear/load and mux decode. Purely combinational.
*/
`timescale 1ns/1ps
module ad_control (
  // Selection
  input wire logic [3:0] format,
  input wire logic [3:0] frame_count,
  // Decoded controls
  output coupler_pkg::ad_ctrl_s ctrl
);
  always_comb begin
    ctrl = '{load: coupler_pkg::REG_NONE, write_decode: 4'h0, read_decode: 4'h0,
             max_count: 4'h1};
    unique case (format)
      4'h0: ctrl.max_count = 4'h1;
      4'h1, 4'h3: ctrl.max_count = 4'h4;
      4'h2: ctrl.max_count = 4'h3;
      4'h4, 4'h5: ctrl.max_count = 4'h2;
      4'h8: ctrl.max_count = 4'h7;
      4'h9: ctrl.max_count = 4'hA;
      default: ctrl.max_count = 4'h1;
    endcase
    unique case ({format, frame_count})
      8'h01: begin ctrl.load = coupler_pkg::REG_BOTH; ctrl.write_decode = 4'h0; end
      8'h14: ctrl.read_decode = 4'h0;
      8'h13: begin ctrl.load = coupler_pkg::REG_UPPER; ctrl.read_decode = 4'h1; end
      8'h12: ctrl.read_decode = 4'h2;
      8'h11: begin ctrl.load = coupler_pkg::REG_LOWER; ctrl.read_decode = 4'h3; end
      8'h23: begin ctrl.load = coupler_pkg::REG_UPPER; ctrl.write_decode = 4'h1; end
      8'h22: begin ctrl.load = coupler_pkg::REG_LOWER; ctrl.write_decode = 4'h2; end
      8'h21: begin ctrl.load = coupler_pkg::REG_BOTH; ctrl.write_decode = 4'h3; end
      8'h34: ctrl.read_decode = 4'h4;
      8'h33: begin ctrl.load = coupler_pkg::REG_UPPER; ctrl.read_decode = 4'hD; end
      8'h32: begin ctrl.load = coupler_pkg::REG_LOWER; ctrl.read_decode = 4'h6; end
      8'h31: begin ctrl.load = coupler_pkg::REG_BOTH; ctrl.read_decode = 4'h7; end
      8'h42: begin ctrl.load = coupler_pkg::REG_UPPER; ctrl.write_decode = 4'h4; end
      8'h41: begin ctrl.load = coupler_pkg::REG_LOWER; ctrl.write_decode = 4'hE; end
      8'h52: begin ctrl.load = coupler_pkg::REG_UPPER; ctrl.read_decode = 4'h4; end
      8'h51: begin ctrl.load = coupler_pkg::REG_LOWER; ctrl.read_decode = 4'h8; end
      8'h61: begin ctrl.load = coupler_pkg::REG_UPPER; ctrl.write_decode = 4'h5; end
      8'h71: begin ctrl.load = coupler_pkg::REG_BOTH; ctrl.read_decode = 4'h8; end
      8'h87: begin ctrl.load = coupler_pkg::REG_UPPER; ctrl.write_decode = 4'h6; end
      8'h86: begin ctrl.load = coupler_pkg::REG_BOTH; ctrl.write_decode = 4'h7; end
      8'h85: begin ctrl.load = coupler_pkg::REG_LOWER; ctrl.write_decode = 4'h8; end
      8'h84: begin ctrl.load = coupler_pkg::REG_BOTH; ctrl.write_decode = 4'h9; end
      8'h83: begin ctrl.load = coupler_pkg::REG_UPPER; ctrl.write_decode = 4'hA; end
      8'h82: begin ctrl.load = coupler_pkg::REG_LOWER; ctrl.write_decode = 4'hB; end
      8'h81: begin ctrl.load = coupler_pkg::REG_BOTH; ctrl.write_decode = 4'hE; end
      8'h9A: ctrl.read_decode = 4'hA;
      8'h99: begin ctrl.load = coupler_pkg::REG_UPPER; ctrl.read_decode = 4'hB; end
      8'h98: begin ctrl.load = coupler_pkg::REG_LOWER; ctrl.read_decode = 4'h9; end
      8'h97: ctrl.read_decode = 4'hC;
      8'h96: begin ctrl.load = coupler_pkg::REG_UPPER; ctrl.read_decode = 4'hD; end
      8'h95: begin ctrl.load = coupler_pkg::REG_LOWER; ctrl.read_decode = 4'hE; end
      8'h94: ctrl.read_decode = 4'h4;
      8'h93: begin ctrl.load = coupler_pkg::REG_UPPER; ctrl.read_decode = 4'hD; end
      8'h92: begin ctrl.load = coupler_pkg::REG_LOWER; ctrl.read_decode = 4'hF; end
      8'h91: begin ctrl.load = coupler_pkg::REG_UPPER; ctrl.read_decode = 4'h7; end
      default: ctrl.load = coupler_pkg::REG_NONE;
    endcase
  end
endmodule : ad_control

// ==== tb/subsystem_proc_model.sv ====
/*
  Subsystem processor model: echoes the initiation clear, requests input
  after go and again a while after each non-terminating reply, returns parity check.
  Assumes one-cycle coupler strobes on ref_clk.
*/
`timescale 1ns/1ps
module subsystem_proc_model #(
  parameter int unsigned REQ_DELAY = 30
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Coupler strobes
  input wire logic coupler_reply,
  input wire logic coupler_terminate,
  input wire logic proc_master_clear,
  input wire logic go,
  // Processor answers
  output logic processor_clear_echo,
  output logic input_request,
  output logic parity_check
);
  int unsigned wait_cnt;
  logic in_xfer;
  // ==========================================================
  // Processor sequencing
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      processor_clear_echo <= 1'b0;
      input_request <= 1'b0;
      parity_check <= 1'b0;
      in_xfer <= 1'b0;
      wait_cnt <= 0;
    end else begin
      processor_clear_echo <= proc_master_clear;
      parity_check <= coupler_reply;
      if (go) begin
        in_xfer <= 1'b1;
        input_request <= 1'b1;
      end else if (coupler_reply) begin
        input_request <= 1'b0;
        in_xfer <= !coupler_terminate;
        wait_cnt <= REQ_DELAY;
      end else if (in_xfer && !input_request) begin
        if (wait_cnt == 0) begin
          input_request <= 1'b1;
        end else begin
          wait_cnt <= wait_cnt - 1;
        end
      end
    end
  end
endmodule : subsystem_proc_model

// ==== tb/testbench.sv ====
/*
  Self-checking bench: A/D lookup, then an autoload through access A.
  Assumes the subsystem processor model beside the coupler.
*/
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  coupler_pkg::chan_in_s chan_a = '0;
  logic [11:0] chan_a_data = 12'h000;
  logic [11:0] hi, lo;
  logic [3:0] format = 4'h0;
  logic [3:0] status_select_lines = 4'h0;
  logic [1:0] data_path = 2'h0;
  logic [1:0] status_code, reg_load;
  logic [3:0] write_decode, read_decode;
  logic proc_inactive = 1'b0;
  logic input_request, parity_check, processor_clear_echo, chan_a_inactive;
  logic chan_a_empty, coupler_reply, coupler_terminate, proc_master_clear;
  logic go, connect_a, coupler_ready;
  logic [15:0] coupler_input_word_lines;
  logic [3:0] frame_count;
  int n_fail = 0;
  int num_checks = 0;
  // Format, load, decode at the reset frame count of 1.
  logic [9:0] ad_tab [4] = '{{4'h0, 2'h3, 4'h0}, {4'h1, 2'h2, 4'h3},
    {4'h6, 2'h1, 4'h5}, {4'h7, 2'h3, 4'h8}};
  // ==========================================================
  // Clock, design and partner
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  channel_coupler #(.DEADMAN_CYCLES(2000)) dut (.ref_clk(ref_clk), .arst_n(arst_n),
    .chan_a(chan_a), .chan_b('0), .chan_a_data(chan_a_data), .chan_b_data(12'h000),
    .chan_a_inactive(chan_a_inactive), .chan_b_inactive(), .chan_a_empty(chan_a_empty),
    .chan_b_empty(), .chan_a_full(), .chan_b_full(), .chan_out_data(), .dual_access(1'b1),
    .format(format), .data_path(data_path), .status_select_lines(status_select_lines),
    .status_sources(16'h0000), .proc_inactive(proc_inactive),
    .processor_clear_echo(processor_clear_echo), .input_request(input_request),
    .parity_check(parity_check), .status_code(status_code), .status_input_lines(),
    .coupler_input_word_lines(coupler_input_word_lines), .coupler_reply(coupler_reply),
    .coupler_ready(coupler_ready), .coupler_terminate(coupler_terminate), .cycle_stop(),
    .proc_master_clear(proc_master_clear), .force_function(), .go(go),
    .connect_a(connect_a), .connect_b(), .reserved(), .frame_count(frame_count),
    .write_decode(write_decode), .read_decode(read_decode), .reg_load(reg_load));
  subsystem_proc_model ssp (.ref_clk(ref_clk), .arst_n(arst_n), .coupler_reply(coupler_reply),
    .coupler_terminate(coupler_terminate), .proc_master_clear(proc_master_clear), .go(go),
    .processor_clear_echo(processor_clear_echo), .input_request(input_request),
    .parity_check(parity_check));
  // ==========================================================
  // Tasks
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  function automatic logic pick(input int k);
    case (k)
      0: return connect_a;
      1: return chan_a_inactive;
      2: return coupler_ready;
      3: return chan_a_empty;
      4: return coupler_reply;
      5: return coupler_terminate;
      default: return !connect_a;
    endcase
  endfunction : pick
  task automatic wait_for(input int k, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge ref_clk);
      #1;
      if (pick(k) === 1'b1) begin
        num_checks++;
        return;
      end
    end
    $display("Error wait %0d expected 1 seen 0", k);
    n_fail++;
    conclude();
  endtask : wait_for
  // Raises one channel strobe for a cycle: 0 function, 1 active, 2 inactive, 3 full.
  task automatic pulse(input int k, input logic [11:0] d);
    @(posedge ref_clk);
    chan_a_data <= d;
    chan_a <= coupler_pkg::chan_in_s'(4'h8 >> k);
    @(posedge ref_clk);
    chan_a <= '0;
  endtask : pulse
  // ==========================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      format <= ad_tab[i][9:6];
      @(posedge ref_clk);
      #1;
      check("ad_load", 16'(reg_load), 16'(ad_tab[i][5:4]));
      check("ad_decode", 16'(ad_tab[i][6] ? read_decode : write_decode),
        16'(ad_tab[i][3:0]));
      check("ad_other", 16'(ad_tab[i][6] ? write_decode : read_decode), 16'h0000);
    end
    @(posedge ref_clk);
    format <= 4'h0;
    status_select_lines <= 4'h4;
    @(posedge ref_clk);
    #1;
    check("status_code", 16'(status_code), 16'h0002);
    $display("test ad_lookup done");
    pulse(0, coupler_pkg::AUTOLOAD_CODE);
    wait_for(0, 40);
    wait_for(1, 40);
    wait_for(2, 20);
    pulse(1, 12'h000);
    for (int w = 0; w < 2; w++) begin
      hi = 12'h9A0 + 12'(w);
      lo = 12'h4B1 + 12'(w);
      pulse(3, hi);
      wait_for(3, 40);
      pulse(3, lo);
      wait_for(3, 40);
      if (w == 1) begin
        pulse(2, 12'h000);
      end
      wait_for(w == 1 ? 5 : 4, 80);
      check("word", coupler_input_word_lines, {hi[7:0], lo[7:0]});
      check("reply", 16'(coupler_reply), 16'h0001);
    end
    repeat (3) @(posedge ref_clk);
    check("frame_count", 16'(frame_count), 16'h0001);
    $display("test autoload done");
    @(posedge ref_clk);
    proc_inactive <= 1'b1;
    @(posedge ref_clk);
    proc_inactive <= 1'b0;
    wait_for(6, 40);
    $display("test drop done");
    conclude();
  end
endmodule : testbench
